// File: verilog/gate_msg_pkg.sv
// constants for the gate driver status and timing message responder
package gate_msg_pkg;

  // message identifiers, low six bits of every header
  localparam logic [5:0] MSG_STATUS_A = 6'h05;
  localparam logic [5:0] MSG_STATUS_B = 6'h06;
  localparam logic [5:0] MSG_SET_TIMING = 6'h07;
  localparam logic [5:0] MSG_GET_TIMING = 6'h08;

  // header kind bits 7:6
  localparam logic [1:0] KIND_NACK = 2'h0;
  localparam logic [1:0] KIND_ACK = 2'h1;
  localparam logic [1:0] KIND_UNSOL = 2'h2;
  // host requests carry this kind in bits 7:6
  localparam logic [1:0] KIND_REQUEST = 2'h2;

  // status b implemented bit positions
  localparam int STB_XUVLO_BIT = 2;
  localparam int STB_XOC_BIT = 3;
  localparam int STB_CFG_LOST_BIT = 4;
  localparam int STB_UV5_BIT = 5;

  // timing field positions
  localparam int DEAD_LSB = 2;
  localparam int DEAD_MSB = 4;
  localparam int BLANK_LSB = 0;
  localparam int BLANK_MSB = 1;
  localparam int RSVD_LSB = 5;

  // reset values
  localparam logic [4:0] TIMING_RESET = 5'h00;
  localparam logic CFG_LOST_RESET = 1'b1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // timing figures
  localparam int CLK_MHZ = 200;
  localparam int DEAD_MAX_NS = 2000;
  localparam int DEAD_STEP_NS = 250;
  localparam int BLANK_MAX_NS = 4000;
  localparam int DEAD_MAX_CYC = DEAD_MAX_NS * CLK_MHZ / 1000;
  localparam int DEAD_STEP_CYC = DEAD_STEP_NS * CLK_MHZ / 1000;
  localparam int BLANK_MAX_CYC = BLANK_MAX_NS * CLK_MHZ / 1000;

endpackage : gate_msg_pkg

// File: verilog/gate_msg_responder.sv
// message responder for status reports and gate timing configuration
// Functional notes
// - status a reply header: 05H not acknowledged, 45H acknowledged.
// - status a may be sent unprompted with header 85H.
// - status a bits 0..4: temp warning, overtemp, input uv, driver ov, input ov.
// - status a bits 5..7: buck overcurrent, buck uv warning, buck brown-out.
// - status b headers: 06H nack, 46H ack, 86H unsolicited.
// - status b bit2 gate uv, bit3 transistor overcurrent, bit5 5 V uv.
// - status b bit4 means configuration lost; reads one after start-up.
// - timing write reply header: 07H nack, 47H ack.
// - dead time in bits 4:2, 000 is 2000 ns, minus 250 ns per code.
// - blanking in bits 1:0: 4 us, 2 us, 1 us, 500 ns.
// - timing read reply header 08H/48H, same layout, bits 7:5 zero.
// - configuration lost set by internal reset, cleared by configuration message.
`timescale 1ns/1ps
`default_nettype none

module gate_msg_responder
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // decoded request from the link framer
  input  wire logic       i_req_valid,
  input  wire logic [7:0] i_req_cmd,
  input  wire logic [7:0] i_req_data,
  input  wire logic       i_req_error,
  output var  logic       o_req_ready,
  // reply frame to the link framer
  output var  logic       o_tx_valid,
  output var  logic [7:0] o_tx_header,
  output var  logic [7:0] o_tx_payload,
  input  wire logic       i_tx_ready,
  // asynchronous fault detector levels
  input  wire logic [7:0] i_fault_a,
  input  wire logic       i_gate_uv,
  input  wire logic       i_ext_oc,
  input  wire logic       i_ldo5_uv,
  input  wire logic       i_brownout,
  // timing settings to the gate stage
  output var  logic [2:0] o_dead_code,
  output var  logic [1:0] o_blank_code,
  output var  logic [9:0] o_dead_cycles,
  output var  logic [9:0] o_blank_cycles
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [7:0] header(input logic [1:0] kind, input logic [5:0] id);
    header = {kind, id};
  endfunction : header

  function automatic logic [9:0] dead_cyc(input logic [2:0] code);
    dead_cyc = 10'(gate_msg_pkg::DEAD_MAX_CYC - gate_msg_pkg::DEAD_STEP_CYC * int'(code));
  endfunction : dead_cyc

  function automatic logic [9:0] blank_cyc(input logic [1:0] code);
    blank_cyc = 10'(gate_msg_pkg::BLANK_MAX_CYC >> code);
  endfunction : blank_cyc

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [7:0] sync1_a;
  logic [7:0] sync2_a;
  logic [3:0] sync1_b;
  logic [3:0] sync2_b;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_a <= 8'h00;
      sync2_a <= 8'h00;
      sync1_b <= 4'h0;
      sync2_b <= 4'h0;
    end
    else
    begin
      sync1_a <= i_fault_a;
      sync2_a <= sync1_a;
      sync1_b <= {i_brownout, i_ldo5_uv, i_ext_oc, i_gate_uv};
      sync2_b <= sync1_b;
    end
  end

  // ************************************************************
  // responder state
  // ************************************************************
  logic [4:0] timing;
  logic       cfg_lost;
  logic [7:0] prev_a;
  logic [7:0] prev_b;
  logic       pend_a;
  logic       pend_b;
  logic       tx_valid;
  logic [7:0] tx_header;
  logic [7:0] tx_payload;
  logic       req_ready;

  logic [4:0] next_timing;
  logic       next_cfg_lost;
  logic       next_pend_a;
  logic       next_pend_b;
  logic       next_tx_valid;
  logic [7:0] next_tx_header;
  logic [7:0] next_tx_payload;
  logic       next_req_ready;

  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic       req_take;
  logic       cfg_clear;
  logic       sent_a;
  logic       sent_b;

  always_comb
  begin
    // buck flags in the high bits
    stat_a = sync2_a;
    stat_b = gate_msg_pkg::BYTE_ZERO;
    stat_b[gate_msg_pkg::STB_XUVLO_BIT] = sync2_b[0];
    stat_b[gate_msg_pkg::STB_XOC_BIT] = sync2_b[1];
    stat_b[gate_msg_pkg::STB_UV5_BIT] = sync2_b[2];
    stat_b[gate_msg_pkg::STB_CFG_LOST_BIT] = cfg_lost;

    next_timing = timing;
    next_tx_valid = tx_valid;
    next_tx_header = tx_header;
    next_tx_payload = tx_payload;
    cfg_clear = 1'b0;
    sent_a = 1'b0;
    sent_b = 1'b0;
    req_take = i_req_valid && req_ready;

    if (tx_valid && i_tx_ready)
    begin
      next_tx_valid = 1'b0;
    end

    if (req_take && i_req_cmd[7:6] == gate_msg_pkg::KIND_REQUEST)
    begin
      next_tx_payload = gate_msg_pkg::BYTE_ZERO;
      case (i_req_cmd[5:0])
        gate_msg_pkg::MSG_STATUS_A:
        begin
          next_tx_valid = 1'b1;
          next_tx_header = header(i_req_error ? gate_msg_pkg::KIND_NACK
                                              : gate_msg_pkg::KIND_ACK,
                                  gate_msg_pkg::MSG_STATUS_A);
          next_tx_payload = i_req_error ? gate_msg_pkg::BYTE_ZERO : stat_a;
        end
        gate_msg_pkg::MSG_STATUS_B:
        begin
          next_tx_valid = 1'b1;
          next_tx_header = header(i_req_error ? gate_msg_pkg::KIND_NACK
                                              : gate_msg_pkg::KIND_ACK,
                                  gate_msg_pkg::MSG_STATUS_B);
          next_tx_payload = i_req_error ? gate_msg_pkg::BYTE_ZERO : stat_b;
        end
        gate_msg_pkg::MSG_SET_TIMING:
        begin
          // write refused on link error or reserved bits set
          next_tx_valid = 1'b1;
          if (i_req_error || i_req_data[7:gate_msg_pkg::RSVD_LSB] != 3'h0)
          begin
            next_tx_header = header(gate_msg_pkg::KIND_NACK, gate_msg_pkg::MSG_SET_TIMING);
          end
          else
          begin
            // dead time and blanking stored together
            next_timing = i_req_data[gate_msg_pkg::DEAD_MSB:gate_msg_pkg::BLANK_LSB];
            cfg_clear = 1'b1;
            next_tx_header = header(gate_msg_pkg::KIND_ACK, gate_msg_pkg::MSG_SET_TIMING);
            next_tx_payload = {3'h0, i_req_data[gate_msg_pkg::DEAD_MSB:gate_msg_pkg::BLANK_LSB]};
          end
        end
        gate_msg_pkg::MSG_GET_TIMING:
        begin
          next_tx_valid = 1'b1;
          next_tx_header = header(i_req_error ? gate_msg_pkg::KIND_NACK
                                              : gate_msg_pkg::KIND_ACK,
                                  gate_msg_pkg::MSG_GET_TIMING);
          next_tx_payload = i_req_error ? gate_msg_pkg::BYTE_ZERO : {3'h0, timing};
        end
        default:
        begin
          // other messages belong to other responders
          next_tx_valid = next_tx_valid;
        end
      endcase
    end
    else if (!next_tx_valid && !req_take && pend_a)
    begin
      next_tx_valid = 1'b1;
      next_tx_header = header(gate_msg_pkg::KIND_UNSOL, gate_msg_pkg::MSG_STATUS_A);
      next_tx_payload = stat_a;
      sent_a = 1'b1;
    end
    else if (!next_tx_valid && !req_take && pend_b)
    begin
      next_tx_valid = 1'b1;
      next_tx_header = header(gate_msg_pkg::KIND_UNSOL, gate_msg_pkg::MSG_STATUS_B);
      next_tx_payload = stat_b;
      sent_b = 1'b1;
    end

    // a newly raised flag wins over the send that clears the pending bit
    next_pend_a = (pend_a && !sent_a) || |(stat_a & ~prev_a);
    next_pend_b = (pend_b && !sent_b) || |(stat_b & ~prev_b);
    // brown-out sets, set wins over clear
    next_cfg_lost = (cfg_lost && !cfg_clear) || sync2_b[3];
    // requests wait while a reply is still outstanding
    next_req_ready = !next_tx_valid;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timing <= gate_msg_pkg::TIMING_RESET;
      cfg_lost <= gate_msg_pkg::CFG_LOST_RESET;
      prev_a <= gate_msg_pkg::BYTE_ZERO;
      prev_b <= gate_msg_pkg::BYTE_ZERO;
      pend_a <= 1'b0;
      pend_b <= 1'b0;
      tx_valid <= 1'b0;
      tx_header <= gate_msg_pkg::BYTE_ZERO;
      tx_payload <= gate_msg_pkg::BYTE_ZERO;
      req_ready <= 1'b0;
    end
    else
    begin
      timing <= next_timing;
      cfg_lost <= next_cfg_lost;
      prev_a <= stat_a;
      prev_b <= stat_b;
      pend_a <= next_pend_a;
      pend_b <= next_pend_b;
      tx_valid <= next_tx_valid;
      tx_header <= next_tx_header;
      tx_payload <= next_tx_payload;
      req_ready <= next_req_ready;
    end
  end

  // ************************************************************
  // timing outputs
  // ************************************************************
  logic [9:0] dead_cycles;
  logic [9:0] blank_cycles;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dead_cycles <= 10'(gate_msg_pkg::DEAD_MAX_CYC);
      blank_cycles <= 10'(gate_msg_pkg::BLANK_MAX_CYC);
    end
    else
    begin
      dead_cycles <= dead_cyc(next_timing[gate_msg_pkg::DEAD_MSB:gate_msg_pkg::DEAD_LSB]);
      blank_cycles <= blank_cyc(next_timing[gate_msg_pkg::BLANK_MSB:gate_msg_pkg::BLANK_LSB]);
    end
  end

  assign o_req_ready = req_ready;
  assign o_tx_valid = tx_valid;
  assign o_tx_header = tx_header;
  assign o_tx_payload = tx_payload;
  assign o_dead_code = timing[gate_msg_pkg::DEAD_MSB:gate_msg_pkg::DEAD_LSB];
  assign o_blank_code = timing[gate_msg_pkg::BLANK_MSB:gate_msg_pkg::BLANK_LSB];
  assign o_dead_cycles = dead_cycles;
  assign o_blank_cycles = blank_cycles;

endmodule : gate_msg_responder

`default_nettype wire

// File: dv/gate_msg_checker.sv
// concurrent checks on the gate message responder ports
`timescale 1ns/1ps
`default_nettype none
module gate_msg_checker
(
  // watched ports
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_req_valid,
  input wire logic [7:0] i_req_cmd,
  input wire logic [7:0] i_req_data,
  input wire logic       i_req_error,
  input wire logic       o_req_ready,
  input wire logic       o_tx_valid,
  input wire logic [7:0] o_tx_header,
  input wire logic [7:0] o_tx_payload,
  input wire logic       i_tx_ready,
  input wire logic [2:0] o_dead_code,
  input wire logic [1:0] o_blank_code,
  input wire logic [9:0] o_dead_cycles,
  input wire logic [9:0] o_blank_cycles
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic       ok, ng;
  logic [7:0] pd;
  assign ok = i_req_valid && o_req_ready && !i_req_error;
  assign ng = i_req_valid && o_req_ready && i_req_error;
  // write data is held one cycle so the new codes can be matched to it
  always_ff @(posedge i_core_clk)
    pd <= i_req_data;
  AST_A_NACK: assert property (ng && i_req_cmd == 8'h85 |=>
    {o_tx_header, o_tx_payload} == 16'h0500) else $error("status a nack");
  AST_SET_ACK: assert property (ok && i_req_cmd == 8'h87 && i_req_data[7:5] == 3'h0 |=>
    o_tx_header == 8'h47 && {o_dead_code, o_blank_code} == pd[4:0]) else $error("set ack");
  AST_SET_NACK: assert property (ok && i_req_cmd == 8'h87 && i_req_data[7:5] != 3'h0 |=>
    o_tx_header == 8'h07 && $stable(o_dead_code)) else $error("set nack");
  AST_DEAD: assert property (o_dead_cycles == 10'(400 - 50 * o_dead_code))
    else $error("dead cycles");
  AST_BLANK: assert property (o_blank_cycles == 10'(800 >> o_blank_code))
    else $error("blank cycles");
  AST_GET: assert property (ok && i_req_cmd == 8'h88 |=>
    o_tx_header == 8'h48 && o_tx_payload == {3'h0, o_dead_code, o_blank_code}) else $error("get");
  AST_B_RSVD: assert property (o_tx_valid && o_tx_header[5:0] == 6'h06 |->
    (o_tx_payload & 8'hC3) == 8'h00) else $error("status b reserved");
  AST_HOLD: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_header) && $stable(o_tx_payload)) else $error("reply dropped");
  C_SET: cover property (ok && i_req_cmd == 8'h87);
  C_UNSOL: cover property (o_tx_valid && o_tx_header == 8'h85);
  C_STALL: cover property (o_tx_valid && !i_tx_ready);
endmodule : gate_msg_checker
bind gate_msg_responder gate_msg_checker chk (.i_core_clk, .i_rst, .i_req_valid, .i_req_cmd,
  .i_req_data, .i_req_error, .o_req_ready, .o_tx_valid, .o_tx_header, .o_tx_payload,
  .i_tx_ready, .o_dead_code, .o_blank_code, .o_dead_cycles, .o_blank_cycles);
`default_nettype wire

// File: dv/host_link_model.sv
// host model taking reply frames off the link
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
  // clock, reset, pacing and reply frame
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_header,
  input  wire logic [7:0] i_tx_payload,
  output var  logic       o_tx_ready,
  // frame taken, o_got lasts one cycle
  output var  logic       o_got,
  output var  logic [7:0] o_hdr,
  output var  logic [7:0] o_pl
);
  logic [1:0] phase;
  // a slow host takes one cycle in four, so replies must stand meanwhile
  assign o_tx_ready = !i_slow || phase == 2'h3;
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
      {phase, o_got, o_hdr, o_pl} <= 19'h0;
    else
      {phase, o_got, o_hdr, o_pl} <= {phase + 2'h1, i_tx_valid && o_tx_ready,
        i_tx_header, i_tx_payload};
endmodule : host_link_model
`default_nettype wire

// File: dv/test_gate_msg_responder.sv
// self-checking bench for the gate message responder
`timescale 1ns/1ps
`default_nettype none
module test_gate_msg_responder;
  logic        i_core_clk, i_rst, i_req_valid, i_req_error, o_req_ready, i_brownout;
  logic        o_tx_valid, i_tx_ready, slow, got;
  logic [7:0]  i_req_cmd, i_req_data, o_tx_header, o_tx_payload, i_fault_a, gh, gp, d, hv, pv;
  logic [2:0]  sb, o_dead_code;
  logic [1:0]  o_blank_code;
  logic [9:0]  o_dead_cycles, o_blank_cycles;
  logic [31:0] seed = 32'h25E2B568;
  int          num_errors = 0, total_checks = 0, cyc = 0;
  // integer model: queued reply frames, stored timing code and lost flag
  logic [15:0] exp_q[$];
  int          mdl_timing = 0, mdl_lost = 1;
  gate_msg_responder dut (.i_core_clk, .i_rst, .i_req_valid, .i_req_cmd, .i_req_data,
    .i_req_error, .o_req_ready, .o_tx_valid, .o_tx_header, .o_tx_payload, .i_tx_ready,
    .i_fault_a, .i_gate_uv(sb[0]), .i_ext_oc(sb[1]), .i_ldo5_uv(sb[2]), .i_brownout,
    .o_dead_code, .o_blank_code, .o_dead_cycles, .o_blank_cycles);
  host_link_model host (.i_core_clk, .i_rst, .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_header(o_tx_header), .i_tx_payload(o_tx_payload), .o_tx_ready(i_tx_ready),
    .o_got(got), .o_hdr(gh), .o_pl(gp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // every frame the host takes is held against the oldest queued expectation
  task automatic check_reply();
    logic [15:0] want;
    total_checks++;
    if (exp_q.size() == 0)
    begin
      num_errors++;
      $display("BAD reply expected none seen %h", {gh, gp});
    end
    else
    begin
      want = exp_q.pop_front();
      if ({gh, gp} !== want)
      begin
        num_errors++;
        $display("BAD reply expected %h seen %h", want, {gh, gp});
      end
    end
  endtask : check_reply
  task automatic want_reply(input logic [7:0] h, input logic [7:0] p);
    exp_q.push_back({h, p});
  endtask : want_reply
  // a frame still owed after the limit counts as a mismatch
  task automatic wait_replies();
    for (int n = 0; n < 200 && exp_q.size() > 0; n++)
      @(posedge i_core_clk);
    if (exp_q.size() > 0)
    begin
      num_errors++;
      $display("BAD reply count expected 0 seen %0d", exp_q.size());
      exp_q.delete();
    end
  endtask : wait_replies
  // stored codes and gate stage cycle counts against the model, 5 ns per cycle
  task automatic check_timing();
    int dead;
    int blank;
    dead = (2000 - 250 * (mdl_timing / 4)) / 5;
    blank = (4000 >> (mdl_timing % 4)) / 5;
    total_checks++;
    if ({o_dead_code, o_blank_code} !== 5'(mdl_timing) || o_dead_cycles !== 10'(dead)
        || o_blank_cycles !== 10'(blank))
    begin
      num_errors++;
      $display("BAD timing expected %0d %0d %0d seen %0d %0d %0d", mdl_timing, dead, blank,
        {o_dead_code, o_blank_code}, o_dead_cycles, o_blank_cycles);
    end
  endtask : check_timing
  task automatic req(input logic [7:0] c, input logic [7:0] dat, input logic e);
    {i_req_valid, i_req_cmd, i_req_data, i_req_error} <= {1'b1, c, dat, e};
    @(posedge i_core_clk);
    for (int n = 0; n < 200 && o_req_ready !== 1'b1; n++)
      @(posedge i_core_clk);
    i_req_valid <= 1'b0;
  endtask : req
  // frames are looked at mid-cycle, while the host's capture stands
  always @(negedge i_core_clk)
    if (got === 1'b1)
      check_reply();
  // the whole run needs well under a thousand cycles
  always @(posedge i_core_clk)
    if (++cyc == 4000)
    begin
      num_errors++;
      tally_and_finish();
    end
  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    {i_rst, i_req_valid, i_req_error, i_brownout, slow, sb, i_req_cmd, i_req_data,
      i_fault_a} <= 32'h8000_0000;
    want_reply(8'h86, 8'h10);
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    wait_replies();
    check_timing();
    for (int id = 5; id < 9; id++)
    begin
      want_reply(8'(id), 8'h00);
      req(8'h80 | 8'(id), 8'h00, 1'b1);
      wait_replies();
    end
    // other responders' commands and non-request kinds get no frame at all
    req(8'h83, 8'h00, 1'b0);
    repeat (8) @(posedge i_core_clk);
    req(8'h45, 8'h00, 1'b0);
    repeat (8) @(posedge i_core_clk);
    for (int i = 0; i < 8; i++)
    begin
      slow <= seed[0];
      seed = lfsr(seed);
      d = {3'h0, 3'(i), 2'(i)};
      want_reply(8'h47, d);
      req(8'h87, d, 1'b0);
      wait_replies();
      mdl_timing = int'(d);
      mdl_lost = 0;
      check_timing();
      want_reply(8'h48, 8'(mdl_timing));
      req(8'h88, 8'h00, 1'b0);
      wait_replies();
    end
    want_reply(8'h07, 8'h00);
    req(8'h87, seed[15:8] | 8'h20, 1'b0);
    wait_replies();
    check_timing();
    // status b payloads below also show the lost flag cleared by the writes
    for (int k = 0; k < 11; k++)
    begin
      hv = k < 8 ? 8'h05 : 8'h06;
      pv = k < 8 ? 8'h01 << k : ((k == 10 ? 8'h20 : 8'h04 << (k - 8)) | 8'(mdl_lost << 4));
      {sb, i_fault_a} <= 11'h1 << k;
      want_reply(8'h80 | hv, pv);
      wait_replies();
      want_reply(8'h40 | hv, pv);
      req(8'h80 | hv, 8'h00, 1'b0);
      wait_replies();
      {sb, i_fault_a} <= 11'h0;
      repeat (4) @(posedge i_core_clk);
    end
    i_brownout <= 1'b1;
    mdl_lost = 1;
    want_reply(8'h86, 8'h10);
    wait_replies();
    // a second reset brings the default timing and the lost flag back
    i_brownout <= 1'b0;
    i_rst <= 1'b1;
    mdl_timing = 0;
    want_reply(8'h86, 8'h10);
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    wait_replies();
    check_timing();
    want_reply(8'h48, 8'h00);
    req(8'h88, 8'h00, 1'b0);
    wait_replies();
    tally_and_finish();
  end
endmodule : test_gate_msg_responder
`default_nettype wire
